// *** include/mrsc_link_if.sv ***
`timescale 1ns/1ps
interface mrsc_link_if;
	logic wr_stb;
	logic rd_stb;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport serial (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
	modport regs (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// *** include/mrsc_pkg.sv ***
// How it works
// [RQ1] x motion is a saturating signed 8-bit count; reading it clears it
// [RQ2] y motion is a saturating signed 8-bit count; reading it clears it
// [RQ3] frame quality reads as unsigned 8 bits, 0 worst, 255 best
// [RQ4] control register: reset, power-down, reserved, shutter, sleep, manual sleep, wake
// [RQ5] low bits: 0xx no sleep, 110 force sleep, 101 force wake
// [RQ6] controller never writes manual sleep and wake both as one
// [RQ7] manual sleep and wake bits clear themselves once the transition is done
// [RQ8] shutter gates the led output when its bit is one, the reset value
// [RQ9] writing the reset bit resets the whole block; the bit defaults to zero
// [RQ10] sleep enabled and one second without motion enters sleep until motion or wake
// [RQ11] status read freezes both counts; read both before the next status read
// [RQ12] power-down bit one enters power-down; zero, the reset value, runs normally
package mrsc_pkg;
	localparam logic [6:0] ADDR_STATUS = 7'h16;
	localparam logic [6:0] ADDR_DX = 7'h17;
	localparam logic [6:0] ADDR_DY = 7'h18;
	localparam logic [6:0] ADDR_QUALITY = 7'h19;
	localparam logic [6:0] ADDR_CONTROL = 7'h1a;
	localparam logic [7:0] CONTROL_RESET = 8'h0c;
	localparam int BIT_CHIP_RESET = 7;
	localparam int BIT_POWER_DOWN = 6;
	localparam int BIT_SHUTTER_EN = 3;
	localparam int BIT_SLEEP_EN = 2;
	localparam int BIT_SLEEP_NOW = 1;
	localparam int BIT_WAKE_NOW = 0;
	localparam logic [7:0] CONTROL_WMASK = 8'hcf;
	localparam logic [2:0] CMD_FORCE_SLEEP = 3'b110;
	localparam logic [2:0] CMD_FORCE_WAKE = 3'b101;
	localparam int BIT_STATUS_MOTION = 7;
	localparam logic signed [8:0] COUNT_MAX = 9'sh07f;
	localparam logic signed [8:0] COUNT_MIN = -9'sh080;
	localparam int CLK_MHZ = 250;
	localparam int IDLE_TIME_MS = 1000;
	localparam int IDLE_CYCLES = IDLE_TIME_MS * CLK_MHZ * 1000;
	localparam logic [3:0] LAST_BIT = 4'hf;
	localparam logic [3:0] ADDR_LAST_BIT = 4'h7;
endpackage

// *** testbench/mrsc_ctrl_model.sv ***
`timescale 1ns/1ps
module mrsc_ctrl_model
(
	input wire logic line_in,
	output logic sclk_out,
	output logic sdio_out
);
	initial
	begin
		sclk_out = 1'b1;
		sdio_out = 1'b1;
	end
	// after the address of a read the line is let go; toggling shows any bit the device fails to drive
	task automatic xfer(input logic wr, input logic [6:0] adr, input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] bits;
		bits = {wr, adr, wd};
		for (int i = 15; i >= 0; i--)
		begin
			sclk_out = 1'b0;
			if (i > 7 || wr)
				sdio_out = bits[i];
			else
				sdio_out = ~sdio_out;
			#62.5;
			sclk_out = 1'b1;
			if (i < 8)
				rd[i] = line_in;
			#62.5;
		end
	endtask
endmodule

// *** testbench/mrsc_top_checker.sv ***
`timescale 1ns/1ps
module mrsc_top_checker
(
	input wire logic SYS_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic SCLK_IN,
	input wire logic SDIO_OE_OUT,
	input wire logic MOTION_VALID_IN,
	input wire logic [7:0] MOTION_DX_IN,
	input wire logic LED_REQ_IN,
	input wire logic SHUTTER_IN,
	input wire logic LED_OUT,
	input wire logic SLEEP_OUT,
	input wire logic POWER_DOWN_OUT,
	input wire logic CHIP_RESET_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	led_off_a: assert property (!LED_REQ_IN |=> !LED_OUT) else $error("led lit without request");
	led_on_a: assert property (LED_REQ_IN && SHUTTER_IN |=> LED_OUT) else $error("led dark in window");
	reset_idle_a: assert property ($fell(SYS_RST_IN) |-> !POWER_DOWN_OUT && !SLEEP_OUT) else $error("not idle");
	rst_pulse_a: assert property (CHIP_RESET_OUT |=> !CHIP_RESET_OUT) else $error("reset pulse too long");
	rst_clear_a: assert property (CHIP_RESET_OUT |-> ##2 !POWER_DOWN_OUT) else $error("reset kept power-down");
	oe_rise_a: assert property ($rose(SDIO_OE_OUT) |-> !SCLK_IN) else $error("turnaround off fall");
	oe_fall_a: assert property ($fell(SDIO_OE_OUT) |-> SCLK_IN) else $error("release off rise");
	motion_wake_a: assert property (SLEEP_OUT && MOTION_VALID_IN && MOTION_DX_IN != 8'h00 |-> ##[1:4] !SLEEP_OUT) else $error("no wake");
endmodule
bind mrsc_top mrsc_top_checker chk (.SYS_CLK_IN, .SYS_RST_IN, .SCLK_IN, .SDIO_OE_OUT, .MOTION_VALID_IN,
	.MOTION_DX_IN, .LED_REQ_IN, .SHUTTER_IN, .LED_OUT, .SLEEP_OUT, .POWER_DOWN_OUT, .CHIP_RESET_OUT);

// *** testbench/tb_motion_report_and_sleep_control.sv ***
`timescale 1ns/1ps
module tb_motion_report_and_sleep_control;
	logic clk = 1'b0, rst = 1'b1, vld = 1'b0, req = 1'b0, sht = 1'b0;
	logic [7:0] dx = 8'h00, dy = 8'h00, ql = 8'h00, rd;
	logic sck, sdc, sdo, oe, led, slp, pd, crst;
	wire logic line = oe ? sdo : sdc;
	integer n_errors = 0, cmp_count = 0, seed = 71, sx = 0, sy = 0, px, py;
	always #2 clk = ~clk;
	mrsc_top #(.IDLE_LIMIT(200)) dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .SCLK_IN(sck), .SDIO_IN(line),
		.SDIO_OUT(sdo), .SDIO_OE_OUT(oe), .MOTION_VALID_IN(vld), .MOTION_DX_IN(dx), .MOTION_DY_IN(dy),
		.QUALITY_IN(ql), .LED_REQ_IN(req), .SHUTTER_IN(sht), .LED_OUT(led), .SLEEP_OUT(slp),
		.POWER_DOWN_OUT(pd), .CHIP_RESET_OUT(crst));
	mrsc_ctrl_model host (.line_in(line), .sclk_out(sck), .sdio_out(sdc));
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic integer sat(integer v);
		return v > 127 ? 127 : (v < -128 ? -128 : v);
	endfunction
	task automatic r(input logic [6:0] a);
		host.xfer(1'b0, a, 8'h00, rd);
	endtask
	task automatic w(input logic [7:0] d);
		host.xfer(1'b1, 7'h1a, d, rd);
	endtask
	task automatic wt(input logic e);
		int i;
		for (i = 0; i < 400 && slp !== e; i++)
			@(posedge clk);
		if (i == 400)
		begin
			n_errors++;
			stop_test();
		end
	endtask
	task automatic frame();
		@(posedge clk);
		#1;
		vld = 1'b1;
		dx = 8'($random(seed));
		dy = 8'($random(seed));
		ql = 8'($random(seed));
		sx = sat(sx + $signed(dx));
		sy = sat(sy + $signed(dy));
		@(posedge clk);
		#1;
		vld = 1'b0;
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		r(7'h1a);
		chk("ctrl", rd, 8'h0c);
		chk("pd", 8'(pd), 8'h00);
		$display("test reset done");
		repeat (12) frame();
		r(7'h16);
		px = sx;
		py = sy;
		sx = 0;
		sy = 0;
		frame();
		r(7'h17);
		chk("dx", rd, 8'(px));
		r(7'h18);
		chk("dy", rd, 8'(py));
		r(7'h16);
		r(7'h17);
		chk("dx next", rd, 8'(sx));
		r(7'h17);
		chk("dx cleared", rd, 8'h00);
		r(7'h19);
		chk("quality", rd, ql);
		r(7'h30);
		chk("unmapped", rd, 8'h00);
		$display("test motion done");
		w(8'h0e);
		chk("sleep", 8'(slp), 8'h01);
		r(7'h1a);
		chk("ctrl", rd, 8'h0c);
		w(8'h0d);
		chk("sleep", 8'(slp), 8'h00);
		r(7'h1a);
		chk("ctrl", rd, 8'h0c);
		w(8'h08);
		repeat (300) @(posedge clk);
		chk("sleep", 8'(slp), 8'h00);
		w(8'h0c);
		wt(1'b1);
		chk("sleep", 8'(slp), 8'h01);
		frame();
		wt(1'b0);
		chk("sleep", 8'(slp), 8'h00);
		$display("test sleep done");
		@(posedge clk);
		#1;
		req = 1'b1;
		w(8'h00);
		chk("led", 8'(led), 8'h01);
		w(8'h48);
		chk("led", 8'(led), 8'h00);
		chk("pd", 8'(pd), 8'h01);
		@(posedge clk);
		#1;
		sht = 1'b1;
		repeat (2) @(posedge clk);
		chk("led", 8'(led), 8'h01);
		#1;
		req = 1'b0;
		w(8'h80);
		chk("pd", 8'(pd), 8'h00);
		r(7'h1a);
		chk("ctrl", rd, 8'h0c);
		$display("test control done");
		stop_test();
	end
endmodule

// *** verilog/mrsc_serial.sv ***
`timescale 1ns/1ps
module mrsc_serial
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk_pin,
	input wire logic sdio_pin,
	output logic sdio_o,
	output logic sdio_oe,
	mrsc_link_if.serial link
);
	logic sclk_m_q, sclk_s_q, sclk_p_q, sdio_m_q, sdio_s_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic read_q;
	logic [7:0] out_q;
	wire rise = sclk_s_q & ~sclk_p_q;
	wire fall = ~sclk_s_q & sclk_p_q;
	wire addr_done = rise & (cnt_q == mrsc_pkg::ADDR_LAST_BIT);
	wire data_done = rise & (cnt_q == mrsc_pkg::LAST_BIT);
	wire [7:0] shift_next = {shift_q[6:0], sdio_s_q};
	// link clock is only sampled; the first flop feeds nothing but the second
	always_ff @(posedge clk)
	begin
		sclk_m_q <= sclk_pin;
		sclk_s_q <= sclk_m_q;
		sclk_p_q <= sclk_s_q;
		sdio_m_q <= sdio_pin;
		sdio_s_q <= sdio_m_q;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_q <= '0;
			shift_q <= '0;
			read_q <= 1'b0;
			link.addr <= '0;
		end
		else if (rise)
		begin
			cnt_q <= cnt_q + 4'h1;
			shift_q <= shift_next;
			if (addr_done)
			begin
				read_q <= ~shift_next[7];
				link.addr <= shift_next[6:0];
			end
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			link.wr_stb <= 1'b0;
			link.rd_stb <= 1'b0;
			link.wdata <= '0;
		end
		else
		begin
			link.rd_stb <= addr_done & ~shift_next[7];
			link.wr_stb <= data_done & ~read_q;
			link.wdata <= shift_next;
		end
	end
	// read data goes out msb first, each bit set up after a falling edge
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			out_q <= '0;
			sdio_o <= 1'b0;
			sdio_oe <= 1'b0;
		end
		else
		begin
			if (link.rd_stb)
				out_q <= link.rdata;
			else if (fall & sdio_oe)
				out_q <= {out_q[6:0], 1'b0};
			if (fall & read_q & cnt_q[3])
			begin
				sdio_oe <= 1'b1;
				// out_q shifts on this same edge once driving, so take the bit that moves up
				sdio_o <= sdio_oe ? out_q[6] : out_q[7];
			end
			else if (data_done)
				sdio_oe <= 1'b0;
		end
	end
endmodule

// *** verilog/mrsc_top.sv ***
`timescale 1ns/1ps
module mrsc_top
#(
	parameter int IDLE_LIMIT = mrsc_pkg::IDLE_CYCLES
)
(
	input wire logic SYS_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic SCLK_IN,
	input wire logic SDIO_IN,
	output logic SDIO_OUT,
	output logic SDIO_OE_OUT,
	input wire logic MOTION_VALID_IN,
	input wire logic [7:0] MOTION_DX_IN,
	input wire logic [7:0] MOTION_DY_IN,
	input wire logic [7:0] QUALITY_IN,
	input wire logic LED_REQ_IN,
	input wire logic SHUTTER_IN,
	output logic LED_OUT,
	output logic SLEEP_OUT,
	output logic POWER_DOWN_OUT,
	output logic CHIP_RESET_OUT
);
	typedef enum logic {MRSC_AWAKE, MRSC_ASLEEP} mrsc_state_t;
	mrsc_link_if link ();
	logic blk_rst_q;
	logic [7:0] ctrl_q, ctrl_d;
	logic signed [7:0] acc_x_q, acc_y_q, rep_x_q, rep_y_q;
	logic [7:0] quality_q;
	logic [31:0] idle_q;
	mrsc_state_t state_q, state_d;
	wire rst = SYS_RST_IN | blk_rst_q;
	wire rd_status = link.rd_stb & (link.addr == mrsc_pkg::ADDR_STATUS);
	wire rd_dx = link.rd_stb & (link.addr == mrsc_pkg::ADDR_DX);
	wire rd_dy = link.rd_stb & (link.addr == mrsc_pkg::ADDR_DY);
	wire wr_ctrl = link.wr_stb & (link.addr == mrsc_pkg::ADDR_CONTROL);
	wire moving = MOTION_VALID_IN & ((MOTION_DX_IN != '0) | (MOTION_DY_IN != '0));
	wire [2:0] sleep_cmd = ctrl_q[2:0];
	wire force_sleep = (sleep_cmd == mrsc_pkg::CMD_FORCE_SLEEP); // [RQ5]
	wire force_wake = (sleep_cmd == mrsc_pkg::CMD_FORCE_WAKE); // [RQ5]
	wire sleep_en = ctrl_q[mrsc_pkg::BIT_SLEEP_EN];
	wire idle_done = (idle_q >= 32'(IDLE_LIMIT - 1));
	wire motion_pending = (acc_x_q != '0) | (acc_y_q != '0);
	// saturate rather than wrap so a fast swipe never reverses direction
	function automatic logic signed [7:0] sat_add(input logic signed [7:0] a, input logic signed [7:0] b);
		logic signed [8:0] s;
		s = 9'(a) + 9'(b);
		if (s > mrsc_pkg::COUNT_MAX)
			sat_add = 8'(mrsc_pkg::COUNT_MAX);
		else if (s < mrsc_pkg::COUNT_MIN)
			sat_add = 8'(mrsc_pkg::COUNT_MIN);
		else
			sat_add = 8'(s);
	endfunction
	mrsc_serial u_serial
	(
		.clk(SYS_CLK_IN),
		.rst(rst),
		.sclk_pin(SCLK_IN),
		.sdio_pin(SDIO_IN),
		.sdio_o(SDIO_OUT),
		.sdio_oe(SDIO_OE_OUT),
		.link(link.serial)
	);
	always_comb
	begin
		case (link.addr)
			mrsc_pkg::ADDR_STATUS: link.rdata = {motion_pending, 7'h00};
			mrsc_pkg::ADDR_DX: link.rdata = rep_x_q;
			mrsc_pkg::ADDR_DY: link.rdata = rep_y_q;
			mrsc_pkg::ADDR_QUALITY: link.rdata = quality_q; // [RQ3]
			mrsc_pkg::ADDR_CONTROL: link.rdata = ctrl_q;
			default: link.rdata = 8'h00;
		endcase
	end
	// control register; reserved bits read zero, reset bit self-clears via block reset
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (state_q == MRSC_ASLEEP ? force_sleep : force_wake)
			ctrl_d[1:0] = 2'b00; // [RQ7]
		if (wr_ctrl)
			ctrl_d = link.wdata & mrsc_pkg::CONTROL_WMASK; // [RQ4] [RQ6]
	end
	// the write that sets the reset bit restarts everything on the third edge after its strobe
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (SYS_RST_IN)
			blk_rst_q <= 1'b0;
		else
			blk_rst_q <= ctrl_q[mrsc_pkg::BIT_CHIP_RESET] & ~blk_rst_q; // [RQ9]
	end
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (rst)
			ctrl_q <= mrsc_pkg::CONTROL_RESET; // [RQ8] [RQ12]
		else
			ctrl_q <= ctrl_d;
	end
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			MRSC_AWAKE:
				if (force_sleep | (sleep_en & idle_done))
					state_d = MRSC_ASLEEP; // [RQ10] [RQ5]
			MRSC_ASLEEP:
				if (moving | force_wake | ~sleep_en)
					state_d = MRSC_AWAKE; // [RQ10] [RQ5]
			default: state_d = MRSC_AWAKE;
		endcase
	end
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (rst)
		begin
			state_q <= MRSC_AWAKE;
			idle_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			idle_q <= (moving | state_q == MRSC_ASLEEP | ~sleep_en) ? '0 : idle_q + 32'h0000_0001; // [RQ10]
		end
	end
	// status read moves the live sums into the report copies; a second one overwrites them
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (rst)
		begin
			acc_x_q <= '0;
			acc_y_q <= '0;
			rep_x_q <= '0;
			rep_y_q <= '0;
		end
		else if (rd_status)
		begin
			rep_x_q <= acc_x_q; // [RQ11]
			rep_y_q <= acc_y_q; // [RQ11]
			acc_x_q <= MOTION_VALID_IN ? MOTION_DX_IN : '0;
			acc_y_q <= MOTION_VALID_IN ? MOTION_DY_IN : '0;
		end
		else
		begin
			if (MOTION_VALID_IN)
			begin
				acc_x_q <= sat_add(acc_x_q, MOTION_DX_IN); // [RQ1]
				acc_y_q <= sat_add(acc_y_q, MOTION_DY_IN); // [RQ2]
			end
			if (rd_dx)
				rep_x_q <= '0; // [RQ1]
			if (rd_dy)
				rep_y_q <= '0; // [RQ2]
		end
	end
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (rst)
		begin
			quality_q <= '0;
			LED_OUT <= 1'b0;
			SLEEP_OUT <= 1'b0;
			POWER_DOWN_OUT <= 1'b0;
			CHIP_RESET_OUT <= 1'b0;
		end
		else
		begin
			if (MOTION_VALID_IN)
				quality_q <= QUALITY_IN; // [RQ3]
			LED_OUT <= LED_REQ_IN & (SHUTTER_IN | ~ctrl_q[mrsc_pkg::BIT_SHUTTER_EN]); // [RQ8]
			SLEEP_OUT <= (state_q == MRSC_ASLEEP);
			POWER_DOWN_OUT <= ctrl_q[mrsc_pkg::BIT_POWER_DOWN]; // [RQ12]
			CHIP_RESET_OUT <= ctrl_q[mrsc_pkg::BIT_CHIP_RESET]; // [RQ9]
		end
	end
endmodule
